//--- core/fcs_pkg.sv
// constants and types of the flash command sequencer
// assumes a 50 MHz system clock and a byte-wide nonvolatile array port

package fcs_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] FCS_OFS_CMD  = 8'h00;
    localparam logic [7:0] FCS_OFS_AH   = 8'h04;
    localparam logic [7:0] FCS_OFS_AL   = 8'h08;
    localparam logic [7:0] FCS_OFS_D0   = 8'h0C;
    localparam logic [7:0] FCS_OFS_D1   = 8'h10;
    localparam logic [7:0] FCS_OFS_D2   = 8'h14;
    localparam logic [7:0] FCS_OFS_D3   = 8'h18;
    localparam logic [7:0] FCS_OFS_STAT = 8'h1C;
    localparam int         FCS_STAT_BSY = 0;
    localparam int         FCS_STAT_LDR = 1;

    // ****************************************
    // command codes and limits
    // ****************************************
    localparam logic [7:0]  FCS_C_PG_RD  = 8'h01;
    localparam logic [7:0]  FCS_C_PG_WR  = 8'h02;
    localparam logic [7:0]  FCS_C_RSVD   = 8'h03;
    localparam logic [7:0]  FCS_C_VERIFY = 8'h04;
    localparam logic [7:0]  FCS_C_ER_PG  = 8'h05;
    localparam logic [7:0]  FCS_C_ER_ALL = 8'h06;
    localparam logic [7:0]  FCS_C_BY_RD  = 8'h81;
    localparam logic [7:0]  FCS_C_BY_WR  = 8'h82;
    localparam logic [7:0]  FCS_C_NORMAL = 8'h0F;
    localparam logic [7:0]  FCS_C_LOADER = 8'hF0;
    localparam logic [7:0]  FCS_VFY_OK   = 8'h00;
    localparam logic [7:0]  FCS_VFY_BAD  = 8'h01;
    localparam logic [15:0] FCS_PAGE_LIM = 16'h0400;
    localparam logic [15:0] FCS_DBY_MAX  = 16'h0FFF;
    localparam logic [15:0] FCS_LBY_MAX  = 16'hDFFF;
    localparam logic [7:0]  FCS_LHI_LIM  = 8'hE0;
    localparam logic [7:0]  FCS_PG4_LAST = 8'h03;
    localparam logic [7:0]  FCS_PG256_LAST = 8'hFF;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned FCS_CLK_MHZ    = 50;
    localparam int unsigned FCS_T_ERASE_US = 2000;
    localparam int unsigned FCS_T_LPG_US   = 15000;
    localparam int unsigned FCS_T_BYTE_US  = 200;
    localparam int unsigned FCS_T_NPG_US   = 800;
    localparam int unsigned FCS_ERASE_CYC  = FCS_T_ERASE_US * FCS_CLK_MHZ;
    localparam int unsigned FCS_LPG_CYC    = FCS_T_LPG_US * FCS_CLK_MHZ;
    localparam int unsigned FCS_BYTE_CYC   = FCS_T_BYTE_US * FCS_CLK_MHZ;
    localparam int unsigned FCS_NPG_CYC    = FCS_T_NPG_US * FCS_CLK_MHZ;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_ACC   = 3'h1,
        S_RWAIT = 3'h2,
        S_XRD   = 3'h3,
        S_XLAT  = 3'h4,
        S_TIME  = 3'h5,
        S_DONE  = 3'h6
    } fcs_state_t;

    typedef enum logic [2:0] {
        OP_RD    = 3'h0,
        OP_PROG  = 3'h1,
        OP_ERPG4 = 3'h2,
        OP_ERALL = 3'h3,
        OP_ERPG64 = 3'h4
    } fcs_op_t;

    typedef struct packed {
        logic        req;
        fcs_op_t     op;
        logic        prog_space;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fcs_mem_t;

    typedef struct packed {
        fcs_state_t      st;
        logic            mode;
        logic            vfy;
        logic            xsrc;
        fcs_op_t         op;
        logic [7:0]      cmd;
        logic [7:0]      ah;
        logic [7:0]      al;
        logic [3:0][7:0] dat;
        logic [7:0]      idx;
        logic [7:0]      last;
        logic [15:0]     base;
        logic [19:0]     wait_c;
        logic [19:0]     tmr;
        logic            vfail;
        logic [7:0]      xbyte;
        logic            ack;
        logic [31:0]     rdat;
        fcs_mem_t        mem;
        logic            xrd;
        logic [7:0]      xadr;
        logic            stall;
    } fcs_regs_t;

endpackage

//--- core/fcs_seq.sv
// flash command sequencer: register file on classic wishbone, command
// decoder, array access sequencer and core stall
// assumes array and extended RAM read data are valid while the strobe is high
//
// Overview of operation
// R01 - page read fills four data registers
// R02 - page write below 0400H, pre-erased
// R03 - loader page write copies RAM 0..255
// R04 - verify leaves zero or nonzero in command
// R05 - normal page erase clears four bytes
// R06 - loader erase clears aligned 64-byte page
// R07 - erase all clears whole data memory, or lower 56 kB in loader
// R08 - byte read into first data register
// R09 - byte write; loader address up to DFFFH
// R10 - 03H reserved; loader reads not implemented
// R11 - F0H enters loader, 0FH leaves it
// R12 - command starts when code is written
// R13 - core stalled until operation completes
// R14 - peripherals keep running during stall
// R15 - software programs only erased bytes
// R16 - data full erase lasts 2 ms
// R17 - loader timings 15 ms, 2 ms, 200 us
// R18 - setup software should erase all once
// R19 - data memory is 1024 four-byte pages
// R20 - two address and four data registers
// R21 - only lower 56 kB loader writable
// R22 - reserved or absent commands touch nothing

module fcs_seq
    import fcs_pkg::*;
#(
    parameter int unsigned ERASE_CYC = FCS_ERASE_CYC,
    parameter int unsigned LPG_CYC   = FCS_LPG_CYC,
    parameter int unsigned BYTE_CYC  = FCS_BYTE_CYC,
    parameter int unsigned NPG_CYC   = FCS_NPG_CYC
) (
    input  wire logic        clk_i,         // system clock
    input  wire logic        rst_i,         // sync reset
    input  wire logic        wb_cyc_i,      // bus cycle
    input  wire logic        wb_stb_i,      // strobe
    input  wire logic        wb_we_i,       // write
    input  wire logic [3:0]  wb_sel_i,      // byte lanes
    input  wire logic [7:0]  wb_adr_i,      // byte address
    input  wire logic [31:0] wb_dat_i,      // write data
    output logic      [31:0] wb_dat_o,      // read data
    output logic             wb_ack_o,      // acknowledge
    output logic             core_stall_o,  // hold core
    output fcs_mem_t         mem_o,         // array access
    input  wire logic [7:0]  mem_rdata_i,   // array read data
    output logic             extended_data_ram_rd_o,     // ram read strobe
    output logic      [7:0]  extended_data_ram_addr_o,   // ram address
    input  wire logic [7:0]  extended_data_ram_rdata_i   // ram read data
);

    // ****************************************
    // state
    // ****************************************
    fcs_regs_t s_q;
    fcs_regs_t s_d;
    logic        hit;
    logic        commit;
    logic [15:0] pa;
    logic [15:0] pbase;
    logic [31:0] rd;
    logic [7:0]  code;

    assign hit    = wb_cyc_i & wb_stb_i;
    assign commit = s_q.ack & hit & wb_we_i & wb_sel_i[0];
    assign pa     = {s_q.ah, s_q.al};
    assign pbase  = {4'h0, pa[9:0], 2'b00};
    assign code   = wb_dat_i[7:0];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d         = s_q;
        s_d.mem.req = 1'b0;
        s_d.xrd     = 1'b0;
        // bus held off while busy
        s_d.ack     = hit & ~s_q.ack & (s_q.st == S_IDLE); // R13
        case (wb_adr_i)
            FCS_OFS_CMD:  rd = {24'h0, s_q.cmd};
            FCS_OFS_AH:   rd = {24'h0, s_q.ah};
            FCS_OFS_AL:   rd = {24'h0, s_q.al};
            FCS_OFS_D0:   rd = {24'h0, s_q.dat[0]};
            FCS_OFS_D1:   rd = {24'h0, s_q.dat[1]};
            FCS_OFS_D2:   rd = {24'h0, s_q.dat[2]};
            FCS_OFS_D3:   rd = {24'h0, s_q.dat[3]};
            FCS_OFS_STAT: rd = {30'h0, s_q.mode, s_q.stall};
            default:      rd = 32'h0;
        endcase
        s_d.rdat = rd;

        case (s_q.st)
            S_IDLE: begin
                if (commit) begin
                    case (wb_adr_i)
                        FCS_OFS_AH: s_d.ah = code; // R20
                        FCS_OFS_AL: s_d.al = code;
                        FCS_OFS_D0: s_d.dat[0] = code;
                        FCS_OFS_D1: s_d.dat[1] = code;
                        FCS_OFS_D2: s_d.dat[2] = code;
                        FCS_OFS_D3: s_d.dat[3] = code;
                        FCS_OFS_CMD: begin
                            s_d.cmd   = code;
                            s_d.idx   = 8'h00;
                            s_d.xsrc  = 1'b0;
                            s_d.vfy   = 1'b0;
                            s_d.vfail = 1'b0;
                            // decode starts at once, no trigger
                            case (code) // R12
                                FCS_C_LOADER: s_d.mode = 1'b1; // R11
                                FCS_C_NORMAL: s_d.mode = 1'b0; // R11
                                FCS_C_PG_RD, FCS_C_VERIFY: begin
                                    // loader variant absent
                                    if (!s_q.mode && pa < FCS_PAGE_LIM) begin // R10
                                        s_d.op   = OP_RD; // R01
                                        s_d.vfy  = (code == FCS_C_VERIFY); // R04
                                        s_d.base = pbase; // R19
                                        s_d.last = FCS_PG4_LAST;
                                        s_d.st   = S_ACC;
                                    end
                                end
                                FCS_C_BY_RD: begin
                                    if (!s_q.mode && pa <= FCS_DBY_MAX) begin // R08
                                        s_d.op   = OP_RD;
                                        s_d.base = pa;
                                        s_d.last = 8'h00;
                                        s_d.st   = S_ACC;
                                    end
                                end
                                FCS_C_PG_WR: begin
                                    if (!s_q.mode) begin
                                        if (pa < FCS_PAGE_LIM) begin // R02
                                            s_d.op     = OP_PROG;
                                            s_d.base   = pbase;
                                            s_d.last   = FCS_PG4_LAST;
                                            s_d.wait_c = 20'(NPG_CYC);
                                            s_d.st     = S_ACC;
                                        end
                                    end else if (s_q.ah < FCS_LHI_LIM) begin // R03 R21
                                        s_d.op     = OP_PROG;
                                        s_d.xsrc   = 1'b1;
                                        s_d.base   = {s_q.ah, 8'h00};
                                        s_d.last   = FCS_PG256_LAST;
                                        s_d.wait_c = 20'(LPG_CYC); // R17
                                        s_d.st     = S_XRD;
                                    end
                                end
                                FCS_C_BY_WR: begin
                                    if (pa <= (s_q.mode ? FCS_LBY_MAX : FCS_DBY_MAX)) begin // R09
                                        s_d.op     = OP_PROG;
                                        s_d.base   = pa;
                                        s_d.last   = 8'h00;
                                        s_d.wait_c = 20'(BYTE_CYC); // R17
                                        s_d.st     = S_ACC;
                                    end
                                end
                                FCS_C_ER_PG: begin
                                    if (!s_q.mode && pa < FCS_PAGE_LIM) begin // R05
                                        s_d.op     = OP_ERPG4;
                                        s_d.base   = pbase;
                                        s_d.last   = 8'h00;
                                        s_d.wait_c = 20'(ERASE_CYC);
                                        s_d.st     = S_ACC;
                                    end else if (s_q.mode && s_q.ah < FCS_LHI_LIM) begin // R06
                                        s_d.op     = OP_ERPG64;
                                        s_d.base   = {s_q.ah, s_q.al[7:6], 6'h00};
                                        s_d.last   = 8'h00;
                                        s_d.wait_c = 20'(ERASE_CYC); // R17
                                        s_d.st     = S_ACC;
                                    end
                                end
                                FCS_C_ER_ALL: begin
                                    s_d.op     = OP_ERALL; // R07
                                    s_d.base   = 16'h0000;
                                    s_d.last   = 8'h00;
                                    s_d.wait_c = 20'(ERASE_CYC); // R16
                                    s_d.st     = S_ACC;
                                end
                                // reserved and unknown codes do nothing
                                default: ; // R22
                            endcase
                        end
                        default: ;
                    endcase
                end
            end
            S_XRD: begin
                s_d.xrd  = 1'b1;
                s_d.xadr = s_q.idx; // R03
                s_d.st   = S_XLAT;
            end
            S_XLAT: begin
                s_d.xbyte = extended_data_ram_rdata_i;
                s_d.st    = S_ACC;
            end
            S_ACC: begin
                s_d.mem.req        = 1'b1;
                s_d.mem.op         = s_q.op;
                s_d.mem.prog_space = s_q.mode;
                s_d.mem.addr       = s_q.base + {8'h00, s_q.idx};
                s_d.mem.wdata      = s_q.xsrc ? s_q.xbyte : s_q.dat[s_q.idx[1:0]];
                if (s_q.op == OP_RD) begin
                    s_d.st = S_RWAIT;
                end else if (s_q.idx == s_q.last) begin
                    s_d.tmr = s_q.wait_c;
                    s_d.st  = S_TIME;
                end else begin
                    s_d.idx = s_q.idx + 8'h01;
                    s_d.st  = s_q.xsrc ? S_XRD : S_ACC;
                end
            end
            S_RWAIT: begin
                if (s_q.vfy) begin
                    if (mem_rdata_i != s_q.dat[s_q.idx[1:0]]) begin
                        s_d.vfail = 1'b1; // R04
                    end
                end else begin
                    s_d.dat[s_q.idx[1:0]] = mem_rdata_i; // R01 R08
                end
                if (s_q.idx == s_q.last) begin
                    s_d.st = S_DONE;
                end else begin
                    s_d.idx = s_q.idx + 8'h01;
                    s_d.st  = S_ACC;
                end
            end
            S_TIME: begin
                if (s_q.tmr <= 20'h00001) begin
                    s_d.st = S_DONE;
                end else begin
                    s_d.tmr = s_q.tmr - 20'h00001;
                end
            end
            S_DONE: begin
                if (s_q.vfy) begin
                    s_d.cmd = s_q.vfail ? FCS_VFY_BAD : FCS_VFY_OK; // R04
                end
                s_d.st = S_IDLE;
            end
            default: s_d.st = S_IDLE;
        endcase
        // the core is held, and bus accesses get no ack until idle
        s_d.stall = (s_d.st != S_IDLE); // R13 R14
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_dat_o     = s_q.rdat;
    assign wb_ack_o     = s_q.ack;
    assign core_stall_o = s_q.stall;
    assign mem_o        = s_q.mem;
    assign extended_data_ram_rd_o    = s_q.xrd;
    assign extended_data_ram_addr_o  = s_q.xadr;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_cmd_wr(logic [7:0] c);
        commit && wb_adr_i == FCS_OFS_CMD && code == c;
    endsequence

    a_cmd_starts: assert property (s_cmd_wr(FCS_C_ER_ALL) |=> core_stall_o [*8]) // R12
        else $error("erase all did not start at once");
    a_busy_no_ack: assert property (s_q.st != S_IDLE |=> !wb_ack_o) // R13
        else $error("bus answered while busy");
    a_enter_loader: assert property (s_cmd_wr(FCS_C_LOADER) |=> s_q.mode && !core_stall_o) // R11
        else $error("loader mode not entered");
    a_leave_loader: assert property (s_cmd_wr(FCS_C_NORMAL) |=> !s_q.mode ##1 !s_q.mode) // R11
        else $error("normal mode not entered");
    a_reserved_quiet: assert property (s_cmd_wr(FCS_C_RSVD) |=> (!mem_o.req && !core_stall_o) [*3]) // R22
        else $error("reserved code caused activity");
    a_ldr_no_read: assert property (mem_o.req && mem_o.prog_space |-> mem_o.op != OP_RD) // R10
        else $error("read issued in loader mode");
    a_data_range: assert property (mem_o.req && !mem_o.prog_space |-> mem_o.addr <= FCS_DBY_MAX) // R02
        else $error("data access out of range");
    a_ldr_limit: assert property (mem_o.req && mem_o.prog_space |-> mem_o.addr <= FCS_LBY_MAX) // R21
        else $error("loader access above limit");
    a_erase64_align: assert property (mem_o.req && mem_o.op == OP_ERPG64 |-> mem_o.addr[5:0] == 6'h00) // R06
        else $error("page erase not aligned");
    a_read_fill: assert property (s_q.st == S_RWAIT && !s_q.vfy
                                  |=> s_q.dat[$past(s_q.idx[1:0])] == $past(mem_rdata_i)) // R01
        else $error("read byte not stored");
    a_verify_code: assert property (s_q.st == S_DONE && s_q.vfy
                                    |=> s_q.cmd == ($past(s_q.vfail) ? FCS_VFY_BAD : FCS_VFY_OK)) // R04
        else $error("verify result wrong");
    a_erase_hold: assert property (mem_o.req && mem_o.op == OP_ERALL |-> core_stall_o [*8]) // R16
        else $error("stall dropped during erase");

endmodule // fcs_seq

//--- bench/fcs_array_model.sv
// behavioural nonvolatile array and extended RAM beside the sequencer
// assumes async read data is only meaningful while a strobe is high
module fcs_array_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] FILL = 8'h3C
) (
    input  wire logic       clk_i,        // system clock
    input  wire fcs_mem_t   mem_i,        // array access
    output logic      [7:0] mem_rdata_o,  // array read data
    input  wire logic       extended_data_ram_rd_i,    // ram strobe
    input  wire logic [7:0] extended_data_ram_addr_i,  // ram address
    output logic      [7:0] extended_data_ram_rdata_o  // ram read data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // storage
    // ****************************************
    logic [7:0] dmem [4096];
    logic [7:0] pmem [65536];
    logic [7:0] extended_data_ram [256];
    logic [7:0] junk = 8'h5A;
    int         acc_n = 0;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            pmem[i] = FILL;
            if (i < 4096) dmem[i] = FILL;
        end
    end
    // released lines show a moving pattern
    always_comb begin
        mem_rdata_o = mem_i.prog_space ? pmem[mem_i.addr] : dmem[mem_i.addr[11:0]];
        if (!mem_i.req) mem_rdata_o = junk;
        extended_data_ram_rdata_o = extended_data_ram_rd_i ? extended_data_ram[extended_data_ram_addr_i] : ~junk;
    end
    always @(posedge clk_i) begin
        junk <= {junk[6:0], ~junk[7]};
        if (mem_i.req) begin
            acc_n++;
            case (mem_i.op)
                OP_PROG: begin
                    if (mem_i.prog_space) pmem[mem_i.addr] &= mem_i.wdata;
                    else dmem[mem_i.addr[11:0]] &= mem_i.wdata;
                end
                OP_ERPG4: for (int i = 0; i < 4; i++) dmem[{mem_i.addr[11:2], 2'(i)}] = 8'hFF;
                OP_ERPG64: for (int i = 0; i < 64; i++) pmem[{mem_i.addr[15:6], 6'(i)}] = 8'hFF;
                OP_ERALL: begin
                    if (mem_i.prog_space) for (int i = 0; i < 16'hE000; i++) pmem[i] = 8'hFF;
                    else for (int i = 0; i < 4096; i++) dmem[i] = 8'hFF;
                end
                default: ;
            endcase
        end
    end
endmodule  // fcs_array_model

//--- bench/tb.sv
// self-checking bench for the flash command sequencer
// assumes the array model file and shortened timing parameters
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcs_pkg::*;
    localparam int ER = 12;
    localparam int LP = 20;
    localparam int BY = 8;
    localparam int NP = 10;
    localparam logic [7:0] FILL = 8'h3C;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [3:0]  sel_v = 4'h1;
    logic [7:0]  ldr_cmd [4] = '{FCS_C_PG_RD, FCS_C_VERIFY, FCS_C_BY_RD, FCS_C_RSVD};
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        core_stall_o;
    fcs_mem_t    mem;
    logic [7:0]  mem_rdata, xadr, xdat;
    logic        xrd;
    logic [31:0] rdq;
    logic [7:0]  exp_d [4096];
    logic [7:0]  exp_p [65536];
    logic [7:0]  d [4];
    logic [15:0] pg, ba;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cyc_n = 0;
    int          acc;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    fcs_seq #(.ERASE_CYC(ER), .LPG_CYC(LP), .BYTE_CYC(BY), .NPG_CYC(NP)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .core_stall_o(core_stall_o), .mem_o(mem), .mem_rdata_i(mem_rdata),
        .extended_data_ram_rd_o(xrd), .extended_data_ram_addr_o(xadr), .extended_data_ram_rdata_i(xdat));
    fcs_array_model #(.FILL(FILL)) u_mod (.clk_i(clk_i), .mem_i(mem), .mem_rdata_o(mem_rdata),
        .extended_data_ram_rd_i(xrd), .extended_data_ram_addr_i(xadr), .extended_data_ram_rdata_o(xdat));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= sel_v;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, v};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 5000);
        rdq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 5000) begin
            fail_count++;
            report_and_stop();
        end else begin
            @(posedge clk_i);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        wb(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 8'h00);
    endtask
    task automatic addr(input logic [15:0] a);
        wr(FCS_OFS_AH, a[15:8]);
        wr(FCS_OFS_AL, a[7:0]);
    endtask
    // issue a command, then a status read that can only finish once idle
    task automatic run(input logic [7:0] c, input int min);
        int t0;
        wr(FCS_OFS_CMD, c);
        t0 = cyc_n;
        if (min > 0) check("stall up", {7'h0, core_stall_o}, 8'h01);
        rd(FCS_OFS_STAT);
        check("stall down", {7'h0, core_stall_o}, 8'h00);
        check("busy", {7'h0, rdq[FCS_STAT_BSY]}, 8'h00);
        if (min > 0) check("duration", {7'h0, (cyc_n - t0) >= min}, 8'h01);
    endtask
    task automatic cmp_mem;
        for (int i = 0; i < 4096; i++) check("data array", u_mod.dmem[i], exp_d[i]);
        for (int i = 0; i < 65536; i++) check("program array", u_mod.pmem[i], exp_p[i]);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h7BC506F9));
        for (int i = 0; i < 65536; i++) exp_p[i] = FILL;
        for (int i = 0; i < 4096; i++) exp_d[i] = 8'hFF;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(FCS_OFS_STAT);
        check("status after reset", rdq[7:0], 8'h00);
        run(FCS_C_ER_ALL, ER);
        cmp_mem();
        for (int k = 0; k < 2; k++) begin
            pg = (k == 0) ? 16'h03FF : 16'($urandom_range(0, 16'h03FE));
            addr(pg);
            for (int i = 0; i < 4; i++) begin
                d[i] = 8'($urandom);
                wr(FCS_OFS_D0 + 8'(4 * i), d[i]);
                exp_d[{pg[9:0], 2'(i)}] = d[i];
            end
            run(FCS_C_PG_WR, NP);
            cmp_mem();
            for (int i = 0; i < 4; i++) wr(FCS_OFS_D0 + 8'(4 * i), 8'h00);
            run(FCS_C_PG_RD, 0);
            for (int i = 0; i < 4; i++) begin
                rd(FCS_OFS_D0 + 8'(4 * i));
                check("page read", rdq[7:0], d[i]);
            end
            run(FCS_C_VERIFY, 0);
            rd(FCS_OFS_CMD);
            check("verify match", rdq[7:0], 8'h00);
            wr(FCS_OFS_D2, ~d[2]);
            run(FCS_C_VERIFY, 0);
            rd(FCS_OFS_CMD);
            check("verify mismatch", {7'h0, rdq[7:0] != 8'h00}, 8'h01);
        end
        for (int i = 0; i < 4; i++) exp_d[{pg[9:0], 2'(i)}] = 8'hFF;
        run(FCS_C_ER_PG, ER);
        cmp_mem();
        ba = {4'h0, pg[9:0], 2'b01};
        d[0] = 8'($urandom);
        exp_d[ba[11:0]] = d[0];
        addr(ba);
        wr(FCS_OFS_D0, d[0]);
        run(FCS_C_BY_WR, BY);
        wr(FCS_OFS_D0, 8'h00);
        run(FCS_C_BY_RD, 0);
        rd(FCS_OFS_D0);
        check("byte read", rdq[7:0], d[0]);
        addr(16'h0FFF);
        run(FCS_C_BY_RD, 0);
        rd(FCS_OFS_D0);
        check("last byte read", rdq[7:0], exp_d[4095]);
        sel_v = 4'h0;
        wr(FCS_OFS_AH, 8'hA5);
        sel_v = 4'h1;
        rd(FCS_OFS_AH);
        check("lane off write", rdq[7:0], 8'h0F);
        acc = u_mod.acc_n;
        addr(16'h0400);
        run(FCS_C_PG_WR, 0);
        run(FCS_C_RSVD, 0);
        check("no access", 8'(u_mod.acc_n - acc), 8'h00);
        run(FCS_C_LOADER, 0);
        run(FCS_C_LOADER, 0);
        rd(FCS_OFS_STAT);
        check("loader mode", {7'h0, rdq[FCS_STAT_LDR]}, 8'h01);
        addr(16'h0010);
        foreach (ldr_cmd[j]) run(ldr_cmd[j], 0);
        check("loader no access", 8'(u_mod.acc_n - acc), 8'h00);
        for (int i = 0; i < 16'hE000; i++) exp_p[i] = 8'hFF;
        run(FCS_C_ER_ALL, ER);
        pg = {8'($urandom_range(0, 8'hDE)), 8'h45};
        for (int i = 0; i < 256; i++) begin
            u_mod.extended_data_ram[i] = 8'($urandom);
            exp_p[{pg[15:8], 8'(i)}] = u_mod.extended_data_ram[i];
        end
        addr(pg);
        run(FCS_C_PG_WR, LP);
        cmp_mem();
        for (int i = 8'h40; i < 8'h80; i++) exp_p[{pg[15:8], 8'(i)}] = 8'hFF;
        run(FCS_C_ER_PG, ER);
        d[0] = 8'($urandom);
        exp_p[16'hDFFF] = d[0];
        addr(16'hDFFF);
        wr(FCS_OFS_D0, d[0]);
        run(FCS_C_BY_WR, BY);
        cmp_mem();
        acc = u_mod.acc_n;
        addr(16'hE000);
        run(FCS_C_BY_WR, 0);
        run(FCS_C_PG_WR, 0);
        check("upper region", 8'(u_mod.acc_n - acc), 8'h00);
        run(FCS_C_NORMAL, 0);
        run(FCS_C_NORMAL, 0);
        rd(FCS_OFS_STAT);
        check("normal mode", {7'h0, rdq[FCS_STAT_LDR]}, 8'h00);
        report_and_stop();
    end
endmodule  // tb
